/* hdl/tcc_pkg.sv */
// Purpose: Shared constants and types for the timer counter capture unit
// Assumes: Word-aligned Avalon-MM register map, 8-bit registers in low bits
// Notes: Byte address of each register is given directly
package tcc_pkg;
    localparam int TCC_AW = 6;
    localparam logic [5:0] TCC_OFS_CNT_H = 6'h00;
    localparam logic [5:0] TCC_OFS_CNT_L = 6'h04;
    localparam logic [5:0] TCC_OFS_RLD_H = 6'h08;
    localparam logic [5:0] TCC_OFS_RLD_L = 6'h0C;
    localparam logic [5:0] TCC_OFS_CTL0 = 6'h10;
    localparam logic [5:0] TCC_OFS_CTL1 = 6'h14;
    localparam logic [5:0] TCC_OFS_CAP_H = 6'h18;
    localparam logic [5:0] TCC_OFS_CAP_L = 6'h1C;
    localparam logic [5:0] TCC_OFS_STAT = 6'h20;
    // Control 0 field positions
    localparam int TCC_C0_EN = 7;
    localparam int TCC_C0_POL = 6;
    localparam int TCC_C0_OUTEN = 5;
    localparam int TCC_C0_PRE_LO = 2;
    localparam int TCC_C0_MODE_LO = 0;
    // Reset values, count restart value on reload, prescaler width
    localparam logic [15:0] TCC_CNT_RST = 16'h0001;
    localparam logic [15:0] TCC_RLD_RST = 16'hFFFF;
    localparam logic [15:0] TCC_CNT_RESTART = 16'h0001;
    localparam logic [7:0] TCC_CTL_RST = 8'h00;
    localparam int TCC_PRE_W = 7;
    typedef enum logic [1:0] {
        TCC_MODE_CONTINUOUS,
        TCC_MODE_COUNTER,
        TCC_MODE_CAPCMP,
        TCC_MODE_DUAL_PWM
    } tcc_mode_t;
    // Interrupt source config: both, capture only, reload only
    typedef enum logic [1:0] {
        TCC_IRQ_BOTH,
        TCC_IRQ_CAPTURE,
        TCC_IRQ_RELOAD,
        TCC_IRQ_BOTH_ALT
    } tcc_irqcfg_t;
endpackage

/* hdl/tcc_edge_det.sv */
// Purpose: Detects the selected edge of the timer input
// Assumes: Input already synchronous to clock
// Notes: One-cycle pulse on the chosen edge
`timescale 1ns/10ps
`default_nettype none
module tcc_edge_det
    import tcc_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic pin,
    input wire logic falling,
    output logic edge_hit
);
    typedef struct packed {
        logic prev;
    } tcc_edge_st_t;
    tcc_edge_st_t st;
    tcc_edge_st_t next_st;

    always_comb begin
        next_st = st;
        next_st.prev = pin;
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // Edge polarity select picks the qualifying transition
    assign edge_hit = falling ? (st.prev & ~pin) : (~st.prev & pin);
endmodule
`default_nettype wire

/* hdl/tcc_timer.sv */
// Purpose: 16-bit timer with counter and capture/compare modes, Avalon-MM slave
// Assumes: Timer input pin synchronous to clock; source at most clock/4
// Notes: Every request gets one wait cycle; reads of high byte latch low byte while the timer is enabled
`timescale 1ns/10ps
`default_nettype none
module tcc_timer
    import tcc_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [TCC_AW-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic timer_pin_in,
    output logic timer_out,
    output logic timer_out_comp,
    output logic timer_comp_oe,
    output logic timer_irq
);
    typedef struct packed {
        logic [15:0] count;
        logic [15:0] reload;
        logic [15:0] capture;
        logic [7:0] hold;
        logic [7:0] ctl0;
        logic [1:0] irqcfg;
        logic [TCC_PRE_W-1:0] pre;
        logic started;
        logic out_lvl;
        logic out_comp;
        logic cap_flag;
        logic rld_flag;
        logic irq;
        logic comp_oe;
        logic waitreq;
        logic [31:0] rdata;
    } tcc_st_t;

    tcc_st_t st;
    tcc_st_t next_st;
    logic edge_hit;
    logic en;
    logic pol;
    logic out_en;
    logic [2:0] pre_sel;
    tcc_mode_t mode;
    logic req;
    logic accept;

    assign en = st.ctl0[TCC_C0_EN];
    assign pol = st.ctl0[TCC_C0_POL];
    assign out_en = st.ctl0[TCC_C0_OUTEN];
    assign pre_sel = st.ctl0[TCC_C0_PRE_LO +: 3];
    assign mode = tcc_mode_t'(st.ctl0[TCC_C0_MODE_LO +: 2]);
    assign req = avs_read | avs_write;
    assign accept = req & ~st.waitreq;

    // Shared pin carries no input in dual output mode
    tcc_edge_det u_edge (
        .clock(clock),
        .rst_n(rst_n),
        .pin(timer_pin_in & (mode != TCC_MODE_DUAL_PWM)),
        .falling(pol),
        .edge_hit(edge_hit)
    );

    always_comb begin
        logic pre_tick;
        logic reload_hit;
        logic cap_evt;
        logic rld_evt;
        logic [TCC_PRE_W-1:0] pre_lim;
        pre_tick = 1'b0;
        reload_hit = 1'b0;
        cap_evt = 1'b0;
        rld_evt = 1'b0;
        pre_lim = TCC_PRE_W'((8'h01 << pre_sel) - 8'h01);
        next_st = st;
        next_st.irq = 1'b0;

        // Bus handshake: one wait cycle, then answer
        next_st.waitreq = ~(req & st.waitreq);
        if (req & st.waitreq & avs_read) begin
            next_st.rdata = 32'h0000_0000;
            unique case (avs_address)
                TCC_OFS_CNT_H: next_st.rdata[7:0] = st.count[15:8];
                TCC_OFS_CNT_L: next_st.rdata[7:0] = en ? st.hold : st.count[7:0];
                TCC_OFS_RLD_H: next_st.rdata[7:0] = st.reload[15:8];
                TCC_OFS_RLD_L: next_st.rdata[7:0] = st.reload[7:0];
                TCC_OFS_CTL0: next_st.rdata[7:0] = st.ctl0;
                TCC_OFS_CTL1: next_st.rdata[1:0] = st.irqcfg;
                TCC_OFS_CAP_H: next_st.rdata[7:0] = st.capture[15:8];
                TCC_OFS_CAP_L: next_st.rdata[7:0] = st.capture[7:0];
                TCC_OFS_STAT: next_st.rdata[3:0] = {st.started, st.out_lvl, st.rld_flag, st.cap_flag};
                default: next_st.rdata = 32'h0000_0000;
            endcase
        end

        // Counting; reads touch only the hold register
        if (en) begin
            unique case (mode)
                TCC_MODE_COUNTER: begin
                    if (edge_hit) begin
                        if (st.count == st.reload) begin
                            reload_hit = 1'b1;
                            rld_evt = 1'b1;
                        end else begin
                            next_st.count = st.count + 16'h0001;
                        end
                    end
                end
                TCC_MODE_CAPCMP: begin
                    if (!st.started) begin
                        next_st.started = edge_hit;
                    end else begin
                        if (st.pre == pre_lim) begin
                            next_st.pre = '0;
                            pre_tick = 1'b1;
                        end else begin
                            next_st.pre = st.pre + TCC_PRE_W'(1);
                        end
                        if (pre_tick) begin
                            if (st.count == st.reload) begin
                                reload_hit = 1'b1;
                                rld_evt = 1'b1;
                            end else begin
                                next_st.count = st.count + 16'h0001;
                            end
                        end
                        if (edge_hit) begin
                            next_st.capture = st.count;
                            cap_evt = 1'b1;
                        end
                    end
                end
                TCC_MODE_CONTINUOUS, TCC_MODE_DUAL_PWM: begin
                    if (st.pre == pre_lim) begin
                        next_st.pre = '0;
                        if (st.count == st.reload) begin
                            reload_hit = 1'b1;
                            rld_evt = 1'b1;
                        end else begin
                            next_st.count = st.count + 16'h0001;
                        end
                    end else begin
                        next_st.pre = st.pre + TCC_PRE_W'(1);
                    end
                end
            endcase
            if (reload_hit) begin
                next_st.count = TCC_CNT_RESTART;
                if (out_en) begin
                    next_st.out_lvl = ~st.out_lvl;
                end
            end
        end else begin
            next_st.out_lvl = pol;
            next_st.started = 1'b0;
            next_st.pre = '0;
        end

        // Interrupt source selection in capture/compare mode
        if (mode == TCC_MODE_CAPCMP) begin
            unique case (tcc_irqcfg_t'(st.irqcfg))
                TCC_IRQ_CAPTURE: next_st.irq = cap_evt;
                TCC_IRQ_RELOAD: next_st.irq = rld_evt;
                TCC_IRQ_BOTH, TCC_IRQ_BOTH_ALT: next_st.irq = cap_evt | rld_evt;
            endcase
        end else begin
            next_st.irq = rld_evt;
        end

        // Accepted bus accesses; write-one clears lose to new events
        if (accept & avs_read & (avs_address == TCC_OFS_CNT_H) & en) begin
            next_st.hold = st.count[7:0];
        end
        if (accept & avs_write) begin
            unique case (avs_address)
                TCC_OFS_CNT_H: next_st.count[15:8] = avs_writedata[7:0];
                TCC_OFS_CNT_L: next_st.count[7:0] = avs_writedata[7:0];
                TCC_OFS_RLD_H: next_st.reload[15:8] = avs_writedata[7:0];
                TCC_OFS_RLD_L: next_st.reload[7:0] = avs_writedata[7:0];
                TCC_OFS_CTL0: next_st.ctl0 = avs_writedata[7:0];
                TCC_OFS_CTL1: next_st.irqcfg = avs_writedata[1:0];
                TCC_OFS_STAT: begin
                    if (avs_writedata[0]) begin
                        next_st.cap_flag = 1'b0;
                    end
                    if (avs_writedata[1]) begin
                        next_st.rld_flag = 1'b0;
                    end
                end
                default: next_st.count = next_st.count;
            endcase
        end
        if (cap_evt) begin
            next_st.cap_flag = 1'b1;
        end
        if (rld_evt) begin
            next_st.rld_flag = 1'b1;
        end
        next_st.comp_oe = out_en & (mode == TCC_MODE_DUAL_PWM);
        // Complement kept in its own flop so the pin is driven from a register
        next_st.out_comp = ~next_st.out_lvl;
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            st <= '0;
            st.count <= TCC_CNT_RST;
            st.reload <= TCC_RLD_RST;
            st.ctl0 <= TCC_CTL_RST;
            st.waitreq <= 1'b1;
            st.out_comp <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    assign avs_readdata = st.rdata;
    assign avs_waitrequest = st.waitreq;
    assign timer_out = st.out_lvl;
    assign timer_out_comp = st.out_comp;
    assign timer_comp_oe = st.comp_oe;
    assign timer_irq = st.irq;
endmodule
`default_nettype wire

/* sim/tcc_src.sv */
// Purpose: Signal source on the timer input pin
// Assumes: The bench asks for a number of pin toggles
// Notes: Pin holds its level between bursts
`timescale 1ns/10ps
`default_nettype none
module tcc_src (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [7:0] n_edges,
    input wire logic go,
    output logic pin
);
    logic [7:0] left;
    logic [1:0] gap;
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            left <= 8'h00;
            gap <= 2'h0;
            pin <= 1'b0;
        end else if (go) begin
            left <= n_edges;
        end else if (left != 8'h00) begin
            gap <= gap + 2'h1;
            if (gap == 2'h3) begin
                pin <= !pin;
                left <= left - 8'h01;
            end
        end
    end
endmodule
`default_nettype wire

/* sim/tcc_chk.sv */
// Purpose: Port checks of the timer unit
// Assumes: One clock, synchronous active-low reset
// Notes: Bound to the timer from the bench top
`timescale 1ns/10ps
`default_nettype none
module tcc_chk (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [5:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic timer_out,
    input wire logic timer_out_comp,
    input wire logic timer_comp_oe,
    input wire logic timer_irq
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    a_wait_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("request not answered");
    a_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest) else $error("wait low too long");
    a_idle_waits: assert property (!avs_read && !avs_write |=> avs_waitrequest) else $error("idle answer");
    a_comp_inverse: assert property (timer_out_comp == !timer_out) else $error("comp not inverse");
    a_data_upper: assert property (!avs_waitrequest |-> avs_readdata[31:8] == 24'h0)
        else $error("upper read bits set");
    a_data_holds: assert property (!avs_read |=> $stable(avs_readdata)) else $error("read data moved");
    a_unmapped_zero: assert property (avs_read && !avs_waitrequest && avs_address == 6'h24 |-> avs_readdata == 32'h0)
        else $error("unmapped read not zero");
    a_reset_state: assert property ($rose(rst_n) |-> avs_waitrequest && !timer_irq && !timer_comp_oe && !timer_out)
        else $error("bad state after reset");
endmodule
`default_nettype wire

/* sim/tb_timer_counter_capture_unit.sv */
// Purpose: Self-checking bench for the timer unit
// Assumes: Source toggles the pin every four clocks
// Notes: Counter mode, count reads, capture mode, dual output mode
`timescale 1ns/10ps
`default_nettype none
module tb_timer_counter_capture_unit
    import tcc_pkg::*;
;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic [5:0] avs_address = 6'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic go = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [7:0] n_edges = 8'h00;
    logic [31:0] avs_readdata;
    logic avs_waitrequest, timer_out, timer_out_comp, timer_comp_oe, timer_irq, pin;
    logic [7:0] q;
    logic [7:0] qh;
    int err_total = 0;
    int n_compared = 0;
    int c;
    always #50 clock = !clock;
    tcc_timer tcc_timer_i (.clock, .rst_n, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata,
        .avs_waitrequest, .timer_pin_in(pin), .timer_out, .timer_out_comp, .timer_comp_oe, .timer_irq);
    tcc_src tcc_src_i (.clock, .rst_n, .n_edges, .go, .pin);
    task automatic end_sim;
        if (err_total == 0 && n_compared > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
        n_compared++;
        if (s !== e) begin
            $display("Error %s exp %h got %h", nm, e, s);
            err_total++;
        end
    endtask
    task automatic acc(input logic wr, input logic [5:0] a, input logic [7:0] d);
        int k;
        k = 0;
        @(posedge clock);
        avs_address <= a;
        avs_writedata <= {24'h0, d};
        avs_write <= wr;
        avs_read <= !wr;
        do begin
            @(posedge clock);
            k++;
        end while (avs_waitrequest !== 1'b0 && k < 20);
        q = avs_readdata[7:0];
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        if (avs_waitrequest !== 1'b0) begin
            chk("bus wait", 16'h0, 16'h1);
            end_sim;
        end
    endtask
    task automatic rdc(input string nm, input logic [5:0] a, input logic [7:0] e);
        acc(1'b0, a, 8'h00);
        chk(nm, {8'h0, e}, {8'h0, q});
    endtask
    task automatic irqs(input int n);
        c = 0;
        repeat (n) begin
            @(posedge clock);
            if (timer_irq === 1'b1) c++;
        end
    endtask
    task automatic src(input logic [7:0] n);
        @(posedge clock);
        n_edges <= n;
        go <= 1'b1;
        @(posedge clock);
        go <= 1'b0;
        irqs(4 * n + 8);
    endtask
    task automatic counter_mode;
        rdc("cnt_l", TCC_OFS_CNT_L, 8'h01);
        acc(1'b1, TCC_OFS_CTL0, 8'h3D);
        acc(1'b1, TCC_OFS_CNT_L, 8'h01);
        acc(1'b1, TCC_OFS_RLD_H, 8'h00);
        acc(1'b1, TCC_OFS_RLD_L, 8'h03);
        acc(1'b1, TCC_OFS_CTL0, 8'hBD);
        src(8'h04);
        chk("irq early", 16'h0, c[15:0]);
        rdc("cnt_h", TCC_OFS_CNT_H, 8'h00);
        rdc("cnt_l", TCC_OFS_CNT_L, 8'h03);
        src(8'h02);
        chk("irq reload", 16'h1, c[15:0]);
        chk("out toggle", 16'h1, {15'h0, timer_out});
        rdc("cnt_h", TCC_OFS_CNT_H, 8'h00);
        rdc("cnt_l", TCC_OFS_CNT_L, 8'h01);
    endtask
    task automatic count_reads;
        rdc("cnt_h", TCC_OFS_CNT_H, 8'h00);
        src(8'h02);
        rdc("held", TCC_OFS_CNT_L, 8'h01);
        acc(1'b1, TCC_OFS_CTL0, 8'h3D);
        repeat (2) @(posedge clock);
        chk("out rise", 16'h0, {15'h0, timer_out});
        rdc("live", TCC_OFS_CNT_L, 8'h02);
        acc(1'b1, TCC_OFS_CTL0, 8'h7D);
        repeat (2) @(posedge clock);
        chk("out fall", 16'h1, {15'h0, timer_out});
        acc(1'b1, TCC_OFS_CTL0, 8'hFD);
        src(8'h02);
        rdc("cnt_h", TCC_OFS_CNT_H, 8'h00);
        rdc("fall only", TCC_OFS_CNT_L, 8'h03);
    endtask
    task automatic capture_mode;
        acc(1'b1, TCC_OFS_CTL0, 8'h02);
        acc(1'b1, TCC_OFS_CNT_L, 8'h01);
        acc(1'b1, TCC_OFS_RLD_L, 8'h40);
        acc(1'b1, TCC_OFS_CTL1, 8'h01);
        acc(1'b1, TCC_OFS_CTL0, 8'h82);
        src(8'h02);
        chk("first edge", 16'h0, c[15:0]);
        irqs(140);
        chk("reload masked", 16'h0, c[15:0]);
        src(8'h02);
        chk("capture irq", 16'h1, c[15:0]);
        acc(1'b0, TCC_OFS_CAP_H, 8'h00);
        qh = q;
        acc(1'b0, TCC_OFS_CAP_L, 8'h00);
        chk("cap range", 16'h1, {15'h0, {qh, q} > 16'h0001 && {qh, q} <= 16'h0040});
        acc(1'b1, TCC_OFS_CTL1, 8'h02);
        irqs(70);
        chk("reload irq", 16'h1, {15'h0, c > 0 && c < 3});
    endtask
    task automatic dual_mode;
        rdc("unmapped", 6'h24, 8'h00);
        acc(1'b1, TCC_OFS_CTL0, 8'h63);
        repeat (2) @(posedge clock);
        chk("comp oe", 16'h1, {15'h0, timer_comp_oe});
        chk("comp level", 16'h0, {15'h0, timer_out_comp});
    endtask
    initial begin
        repeat (16) @(posedge clock);
        rst_n <= 1'b1;
        counter_mode();
        count_reads();
        capture_mode();
        dual_mode();
        end_sim;
    end
endmodule
bind tcc_timer tcc_chk tcc_chk_i (.clock, .rst_n, .avs_address, .avs_read, .avs_write, .avs_readdata,
    .avs_waitrequest, .timer_out, .timer_out_comp, .timer_comp_oe, .timer_irq);
`default_nettype wire
